// >>> hdl/rcpc_top.v
// reset cause flags and program counter with axi4-lite register access
//---------------------------------------------------------------
// Function
// - some registers are never initialised by any reset
// - watchdog wake-up resumes operation; registers keep their values apart from the watchdog and power-down flags
// - power-on: pc zero, soft/watchdog/power-down flags set, sw brown-out enable set in software mode, rest cleared
// - reset instr clears soft flag; brown-out sets soft/watchdog/power-down, clears brown-out
// - pin reset in idle/sleep: pc zero, set watchdog, clear power-down; run: set watchdog
// - pin reset in full power: pc zero, flags unchanged
// - watchdog timeout in full/run: pc zero, clear watchdog flag
// - watchdog timeout in idle/sleep: no reset, pc+2, clear watchdog and power-down
// - interrupt wake-up: pc+2, clear power-down flag
// - interrupt wake-up with global enable: load vector 0x08 or 0x18
// - stack full with reset enable: pc zero, set full flag
// - stack underflow with reset enable: pc zero, set underflow flag
// - underflow without reset enable: set flag, pc zero, no reset
// - sw brown-out enable set by power-on in software mode, else zero
// - pc is 21 bits in three bytes; only the low byte is accessible
// - writing low byte copies both latches into upper pc bytes
// - reading low byte copies upper pc bytes into both latches
// - pc bit 0 stays zero; sequential step is two
// - call, relative call, goto and branch load pc directly
// - fetches above implemented memory return zeros
// - reset vector 0x0000, interrupt vectors 0x0008 and 0x0018
//---------------------------------------------------------------
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`include "rcpc_map.vh"
module rcpc_top (
   input  wire        i_ref_clk,
   input  wire        i_rst_b,
   input  wire        i_clk_en,
   // reset and wake sources (pin input synchronised)
   input  wire        i_external_reset_pin_n,
   input  wire        i_brownout_rst,
   input  wire        i_reset_instr,
   input  wire        i_watchdog_timeout,
   input  wire        i_int_wake,
   input  wire        i_int_high,
   input  wire        i_high_prio_global_int_en,
   input  wire        i_low_prio_global_int_en,
   input  wire        i_stack_full,
   input  wire        i_stack_underflow,
   input  wire [1:0]  i_power_state,
   input  wire [4:0]  i_stack_ptr,
   // sequencer
   input  wire        i_advance,
   input  wire        i_jump,
   input  wire [20:0] i_jump_addr,
   input  wire [7:0]  i_fetch_raw,
   // axi4-lite slave
   input  wire [4:0]  i_awaddr,
   input  wire        i_awvalid,
   output reg         o_awready,
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_wstrb,
   input  wire        i_wvalid,
   output reg         o_wready,
   output reg  [1:0]  o_bresp,
   output reg         o_bvalid,
   input  wire        i_bready,
   input  wire [4:0]  i_araddr,
   input  wire        i_arvalid,
   output reg         o_arready,
   output reg  [31:0] o_rdata,
   output reg  [1:0]  o_rresp,
   output reg         o_rvalid,
   input  wire        i_rready,
   // status outputs
   output reg  [20:0] o_pc,
   output reg  [7:0]  o_fetch_data,
   output reg         o_core_reset,
   output reg         o_sw_brownout_enable
);
   // configuration straps (rcpc_cfg register)
   reg  [1:0]  brownout_mode_cfg_ff;
   reg         stack_error_reset_enable_ff;
   reg  [7:0]  rcc_ff;
   reg         ful_ff;
   reg         unf_ff;
   reg  [7:0]  hlat_ff;
   reg  [4:0]  ulat_ff;
   reg         por_done_ff;
   reg         pin_s1_ff;
   reg         pin_s2_ff;
   reg         pin_d_ff;
   reg  [7:0]  nxt_rcc;
   reg         nxt_ful;
   reg         nxt_unf;
   reg  [20:0] nxt_pc;
   reg         nxt_rst;
   reg  [4:0]  aw_a_ff;
   reg  [31:0] w_d_ff;
   reg  [3:0]  w_s_ff;
   reg         aw_h_ff;
   reg         w_h_ff;
   wire        sw_mode = (brownout_mode_cfg_ff == `RCPC_BRN_SW);
   wire        sleep_state = (i_power_state == `RCPC_PS_IDLE) || (i_power_state == `RCPC_PS_SLEEP);
   wire        pin_evt = pin_d_ff & ~pin_s2_ff;
   wire        do_wr = aw_h_ff & w_h_ff & ~o_bvalid;
   wire        do_rd = i_arvalid & o_arready;
   wire        wr_plo = do_wr & (aw_a_ff == `RCPC_A_PLO) & w_s_ff[0];
   wire        rd_plo = do_rd & (i_araddr == `RCPC_A_PLO);
   wire        wake = i_int_wake & sleep_state;
   wire        gie = i_high_prio_global_int_en | i_low_prio_global_int_en;
   wire [20:0] pc_next_seq = o_pc + `RCPC_PC_STEP;

   //---------------------------------------------------------------
   // pin synchroniser
   //---------------------------------------------------------------
   // two flops then an edge register on the second stage
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_s1_ff <= 1'b1;
         pin_s2_ff <= 1'b1;
         pin_d_ff  <= 1'b1;
      end else if (i_clk_en) begin
         pin_s1_ff <= i_external_reset_pin_n;
         pin_s2_ff <= pin_s1_ff;
         pin_d_ff  <= pin_s2_ff;
      end
   end

   //---------------------------------------------------------------
   // event decode
   //---------------------------------------------------------------
   // highest priority first; only one cause is recorded per cycle
   always @* begin
      nxt_rcc = rcc_ff;
      nxt_ful = ful_ff;
      nxt_unf = unf_ff;
      nxt_pc  = o_pc;
      nxt_rst = 1'b0;
      if (!por_done_ff) begin
         nxt_rcc[`RCPC_B_SOFT] = 1'b1;
         nxt_rcc[`RCPC_B_WDOG] = 1'b1;
         nxt_rcc[`RCPC_B_PDN]  = 1'b1;
         nxt_rcc[`RCPC_B_POR]  = 1'b0;
         nxt_rcc[`RCPC_B_BRN]  = 1'b0;
         nxt_rcc[`RCPC_B_SWBO] = sw_mode;
         nxt_ful = 1'b0;
         nxt_unf = 1'b0;
         nxt_pc  = `RCPC_V_RESET;
         nxt_rst = 1'b1;
      end else if (i_brownout_rst) begin
         nxt_rcc[`RCPC_B_SOFT] = 1'b1;
         nxt_rcc[`RCPC_B_WDOG] = 1'b1;
         nxt_rcc[`RCPC_B_PDN]  = 1'b1;
         nxt_rcc[`RCPC_B_BRN]  = 1'b0;
         nxt_pc  = `RCPC_V_RESET;
         nxt_rst = 1'b1;
      end else if (pin_evt) begin
         nxt_pc  = `RCPC_V_RESET;
         nxt_rst = 1'b1;
         if (sleep_state) begin
            nxt_rcc[`RCPC_B_WDOG] = 1'b1;
            nxt_rcc[`RCPC_B_PDN]  = 1'b0;
         end else if (i_power_state == `RCPC_PS_RUN) begin
            nxt_rcc[`RCPC_B_WDOG] = 1'b1;
         end
      end else if (i_watchdog_timeout) begin
         if (sleep_state) begin
            nxt_rcc[`RCPC_B_WDOG] = 1'b0;
            nxt_rcc[`RCPC_B_PDN]  = 1'b0;
            nxt_pc = pc_next_seq;
         end else begin
            nxt_rcc[`RCPC_B_WDOG] = 1'b0;
            nxt_pc  = `RCPC_V_RESET;
            nxt_rst = 1'b1;
         end
      end else if (i_reset_instr) begin
         nxt_rcc[`RCPC_B_SOFT] = 1'b0;
         nxt_pc  = `RCPC_V_RESET;
         nxt_rst = 1'b1;
      end else if (i_stack_full & stack_error_reset_enable_ff) begin
         nxt_ful = 1'b1;
         nxt_pc  = `RCPC_V_RESET;
         nxt_rst = 1'b1;
      end else if (i_stack_underflow) begin
         nxt_unf = 1'b1;
         nxt_pc  = `RCPC_V_RESET;
         nxt_rst = stack_error_reset_enable_ff;
      end else if (wake) begin
         nxt_rcc[`RCPC_B_PDN] = 1'b0;
         if (gie)
            nxt_pc = i_int_high ? `RCPC_V_HI : `RCPC_V_LO;
         else
            nxt_pc = pc_next_seq;
      end else begin
         // software writes of cause flags and clears of stack flags; hardware set above wins
         if (do_wr && aw_a_ff == `RCPC_A_RCC && w_s_ff[0]) begin
            nxt_rcc[`RCPC_B_PRIO] = w_d_ff[`RCPC_B_PRIO];
            nxt_rcc[`RCPC_B_SOFT:`RCPC_B_BRN] = w_d_ff[`RCPC_B_SOFT:`RCPC_B_BRN];
            if (sw_mode)
               nxt_rcc[`RCPC_B_SWBO] = w_d_ff[`RCPC_B_SWBO];
         end
         if (do_wr && aw_a_ff == `RCPC_A_STK && w_s_ff[0]) begin
            nxt_ful = ful_ff & w_d_ff[`RCPC_B_FUL];
            nxt_unf = unf_ff & w_d_ff[`RCPC_B_UNF];
         end
         // full without reset enable only flags; applied after the clear so the set wins
         if (i_stack_full)
            nxt_ful = 1'b1;
         if (wr_plo)
            nxt_pc = {ulat_ff, hlat_ff, w_d_ff[7:1], 1'b0};
         else if (i_jump)
            nxt_pc = {i_jump_addr[20:1], 1'b0};
         else if (i_advance)
            nxt_pc = pc_next_seq;
      end
      // other resets keep the enable only in software mode
      if (nxt_rst && por_done_ff && !sw_mode)
         nxt_rcc[`RCPC_B_SWBO] = 1'b0;
      nxt_rcc[`RCPC_B_RSVD] = 1'b0;
      nxt_pc[0] = 1'b0;
   end

   //---------------------------------------------------------------
   // state registers
   //---------------------------------------------------------------
   // applied in the recognising cycle; latches have no reset value
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         por_done_ff <= 1'b0;
         rcc_ff <= 8'h00;
         ful_ff <= 1'b0;
         unf_ff <= 1'b0;
         o_pc <= `RCPC_V_RESET;
         o_core_reset <= 1'b1;
         o_sw_brownout_enable <= 1'b0;
         o_fetch_data <= 8'h00;
      end else if (i_clk_en) begin
         por_done_ff <= 1'b1;
         rcc_ff <= nxt_rcc;
         ful_ff <= nxt_ful;
         unf_ff <= nxt_unf;
         o_pc <= nxt_pc;
         o_core_reset <= nxt_rst;
         o_sw_brownout_enable <= nxt_rcc[`RCPC_B_SWBO] & sw_mode;
         o_fetch_data <= (o_pc >= `RCPC_MEM_TOP) ? 8'h00 : i_fetch_raw;
      end
   end

   // holding latches and config keep value across every reset
   always @(posedge i_ref_clk) begin
      if (i_clk_en) begin
         // low byte read snapshots upper bytes
         if (rd_plo) begin
            hlat_ff <= o_pc[15:8];
            ulat_ff <= o_pc[20:16];
         end else if (do_wr && w_s_ff[0]) begin
            if (aw_a_ff == `RCPC_A_HLAT)
               hlat_ff <= w_d_ff[7:0];
            if (aw_a_ff == `RCPC_A_ULAT)
               ulat_ff <= w_d_ff[4:0];
            if (aw_a_ff == `RCPC_A_CFG) begin
               brownout_mode_cfg_ff <= w_d_ff[1:0];
               stack_error_reset_enable_ff <= w_d_ff[2];
            end
         end
      end
   end

   //---------------------------------------------------------------
   // axi4-lite slave
   //---------------------------------------------------------------
   // write channels captured in any order, response after both
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= `RCPC_RESP_OK;
         aw_h_ff <= 1'b0;
         w_h_ff <= 1'b0;
         aw_a_ff <= 5'h00;
         w_d_ff <= 32'h00000000;
         w_s_ff <= 4'h0;
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= `RCPC_RESP_OK;
      end else if (i_clk_en) begin
         o_awready <= ~aw_h_ff & ~o_awready & ~o_bvalid;
         o_wready <= ~w_h_ff & ~o_wready & ~o_bvalid;
         if (i_awvalid & o_awready) begin
            aw_h_ff <= 1'b1;
            aw_a_ff <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (i_wvalid & o_wready) begin
            w_h_ff <= 1'b1;
            w_d_ff <= i_wdata;
            w_s_ff <= i_wstrb;
            o_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_h_ff <= 1'b0;
            w_h_ff <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= (aw_a_ff > `RCPC_A_CFG || aw_a_ff[1:0] != 2'h0) ? `RCPC_RESP_ERR : `RCPC_RESP_OK;
         end else if (o_bvalid & i_bready)
            o_bvalid <= 1'b0;
         o_arready <= ~o_arready & ~o_rvalid;
         if (do_rd) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= `RCPC_RESP_OK;
            case (i_araddr)
               `RCPC_A_RCC:    o_rdata <= {24'h000000, rcc_ff};
               `RCPC_A_STK:    o_rdata <= {24'h000000, ful_ff, unf_ff, 1'b0, i_stack_ptr};
               `RCPC_A_PLO:    o_rdata <= {24'h000000, o_pc[7:0]};
               `RCPC_A_HLAT:   o_rdata <= {24'h000000, hlat_ff};
               `RCPC_A_ULAT:   o_rdata <= {27'h0000000, ulat_ff};
               `RCPC_A_CFG:    o_rdata <= {29'h00000000, stack_error_reset_enable_ff, brownout_mode_cfg_ff};
               default: begin
                  o_rdata <= 32'h00000000;
                  o_rresp <= `RCPC_RESP_ERR;
               end
            endcase
         end else if (o_rvalid & i_rready)
            o_rvalid <= 1'b0;
      end
   end
endmodule

// >>> hdl/rcpc_map.vh
// constants for the reset cause and program counter block
`ifndef RCPC_MAP_VH
`define RCPC_MAP_VH
// register byte addresses
`define RCPC_A_RCC        5'h00
`define RCPC_A_STK        5'h04
`define RCPC_A_PLO        5'h08
`define RCPC_A_HLAT       5'h0C
`define RCPC_A_ULAT       5'h10
`define RCPC_A_CFG        5'h14
`define RCPC_A_PCFULL     5'h18
// reset_cause_control bit positions
`define RCPC_B_PRIO       7
`define RCPC_B_SWBO       6
`define RCPC_B_RSVD       5
`define RCPC_B_SOFT       4
`define RCPC_B_WDOG       3
`define RCPC_B_PDN        2
`define RCPC_B_POR        1
`define RCPC_B_BRN        0
// return_stack_pointer bit positions
`define RCPC_B_FUL        7
`define RCPC_B_UNF        6
// vectors and constants
`define RCPC_V_RESET      21'h000000
`define RCPC_V_HI         21'h000008
`define RCPC_V_LO         21'h000018
`define RCPC_PC_STEP      21'h000002
`define RCPC_BRN_SW       2'h1
`define RCPC_MEM_TOP      21'h010000
`define RCPC_RESP_OK      2'h0
`define RCPC_RESP_ERR     2'h2
// power states
`define RCPC_PS_FULL      2'h0
`define RCPC_PS_RUN       2'h1
`define RCPC_PS_IDLE      2'h2
`define RCPC_PS_SLEEP     2'h3
`endif

// >>> dv/rcpc_checker.sv
// port assertions for the reset cause and pc block
`timescale 1ns/1ns
`include "rcpc_map.vh"
module rcpc_checker (
   input wire        i_ref_clk,
   input wire        i_rst_b,
   input wire        i_clk_en,
   input wire        i_brownout_rst,
   input wire        i_reset_instr,
   input wire        i_watchdog_timeout,
   input wire        i_int_wake,
   input wire        i_int_high,
   input wire        i_high_prio_global_int_en,
   input wire        i_low_prio_global_int_en,
   input wire        i_stack_full,
   input wire        i_stack_underflow,
   input wire [1:0]  i_power_state,
   input wire        i_advance,
   input wire        i_jump,
   input wire [20:0] i_jump_addr,
   input wire [20:0] o_pc,
   input wire [7:0]  o_fetch_data,
   input wire        o_core_reset
);
   //----
   // helpers
   //----
   // running with no reset pulse out and no reset source in apart from the reset pin
   wire calm = i_clk_en & ~o_core_reset & ~(i_brownout_rst | i_reset_instr | i_watchdog_timeout
               | i_stack_full | i_stack_underflow);
   wire quiet = calm & ~i_int_wake;
   wire low_pwr = i_power_state[1];
   wire gie = i_high_prio_global_int_en | i_low_prio_global_int_en;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   //----
   // properties
   //----
   chk_pc_even: assert property (o_pc[0] == 1'b0)
      else $error("pc bit 0 set");
   chk_pc_step: assert property (quiet && i_advance && !i_jump |=> o_pc == $past(o_pc) + `RCPC_PC_STEP)
      else $error("pc step wrong");
   chk_jump_load: assert property (quiet && i_jump |=> o_pc == ($past(i_jump_addr) & 21'h1FFFFE))
      else $error("jump target not loaded");
   chk_reset_vec: assert property (i_clk_en && (i_brownout_rst || i_reset_instr)
      |=> o_pc == `RCPC_V_RESET && o_core_reset) else $error("reset vector missed");
   chk_wdog_run: assert property (i_clk_en && !o_core_reset && i_watchdog_timeout && !low_pwr
      |=> o_pc == `RCPC_V_RESET && o_core_reset) else $error("watchdog reset missed");
   chk_wdog_wake: assert property (i_clk_en && !o_core_reset && i_watchdog_timeout && low_pwr
      && !i_brownout_rst |=> !o_core_reset && o_pc == $past(o_pc) + `RCPC_PC_STEP) else $error("watchdog wake wrong");
   chk_int_vec: assert property (calm && i_int_wake && low_pwr && gie
      |=> o_pc == ($past(i_int_high) ? `RCPC_V_HI : `RCPC_V_LO)) else $error("wake vector wrong");
   chk_fetch_zero: assert property (i_clk_en && o_pc >= `RCPC_MEM_TOP |=> o_fetch_data == 8'h00)
      else $error("fetch above top not zero");
   cov_wdog_wake: cover property (i_watchdog_timeout && low_pwr);
   cov_int_vec: cover property (i_int_wake && gie);
   cov_fetch_top: cover property (o_pc >= `RCPC_MEM_TOP);
endmodule

bind rcpc_top rcpc_checker u_chk (.i_ref_clk, .i_rst_b, .i_clk_en, .i_brownout_rst, .i_reset_instr,
   .i_watchdog_timeout, .i_int_wake, .i_int_high, .i_high_prio_global_int_en, .i_low_prio_global_int_en,
   .i_stack_full, .i_stack_underflow, .i_power_state, .i_advance, .i_jump, .i_jump_addr, .o_pc,
   .o_fetch_data, .o_core_reset);

// >>> dv/rcpc_seq_model.sv
// far side model: reset sources, sequencer strobes and program memory
`timescale 1ns/1ns
module rcpc_seq_model (
   input  wire [7:0]  i_req,
   input  wire [20:0] i_pc,
   output wire [7:0]  o_ev,
   output wire [7:0]  o_fetch_raw
);
   //----
   // strobes and memory
   //----
   // single-cycle strobes pass straight through
   assign o_ev = i_req;
   // memory byte patterned from the address so a zeroed fetch stands out
   assign o_fetch_raw = i_pc[7:0] ^ 8'h5A;
endmodule

// >>> dv/tb_top.sv
// self-checking testbench for the reset cause and pc block
`timescale 1ns/1ns
`include "rcpc_map.vh"
module tb_top;
   logic        clk = 1'b0, rst_b = 1'b0, pin_n = 1'b1, gh = 1'b0, gl = 1'b0, ih = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, en = 1'b1;
   logic [7:0]  req = 8'h00;
   logic [1:0]  ps = 2'h0, rr;
   logic [4:0]  awa = 5'h00, ara = 5'h00;
   logic [20:0] jaddr = 21'h000000;
   logic [31:0] wd = 32'h00000000, rv;
   wire         awr, wrdy, bv, arr, rvd, cr, sbe;
   wire  [1:0]  br, rrsp;
   wire  [31:0] rdat;
   wire  [20:0] pc;
   wire  [7:0]  ev, raw, fd;
   int          n_fail = 0, checks = 0;
   // free-running 20 MHz clock
   always #25 clk = ~clk;
   rcpc_top DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(en), .i_external_reset_pin_n(pin_n),
      .i_brownout_rst(ev[0]), .i_reset_instr(ev[1]), .i_watchdog_timeout(ev[2]), .i_int_wake(ev[3]),
      .i_int_high(ih), .i_high_prio_global_int_en(gh), .i_low_prio_global_int_en(gl),
      .i_stack_full(ev[4]), .i_stack_underflow(ev[5]), .i_power_state(ps), .i_stack_ptr(5'h0A),
      .i_advance(ev[6]), .i_jump(ev[7]), .i_jump_addr(jaddr), .i_fetch_raw(raw), .i_awaddr(awa),
      .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrdy),
      .o_bresp(br), .o_bvalid(bv), .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
      .o_rdata(rdat), .o_rresp(rrsp), .o_rvalid(rvd), .i_rready(rrdy), .o_pc(pc), .o_fetch_data(fd),
      .o_core_reset(cr), .o_sw_brownout_enable(sbe));
   rcpc_seq_model MDL (.i_req(req), .i_pc(pc), .o_ev(ev), .o_fetch_raw(raw));
   //----
   // tasks
   //----
   task automatic finish_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // axi write: address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bit ta = 0, tw = 0;
      @(posedge clk);
      awa <= a;
      awv <= 1'b1;
      wd <= d;
      wv <= 1'b1;
      brdy <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge clk);
         ta = ta | (awr === 1'b1);
         tw = tw | (wrdy === 1'b1);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      do @(posedge clk); while (bv !== 1'b1);
      rr = br;
      brdy <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rvd !== 1'b1);
      rv = rdat;
      rr = rrsp;
      rrdy <= 1'b0;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
      rd(a);
      cmp($sformatf("reg %h", a), {24'h0, e}, rv & {24'h0, m});
   endtask
   // one-cycle strobe from the far side, power state set with it
   task automatic pulse(input int b, input logic [1:0] s);
      @(posedge clk);
      req <= 8'h01 << b;
      ps <= s;
      @(posedge clk);
      req <= 8'h00;
      #1;
   endtask
   task automatic pin_hit(input logic [1:0] s);
      @(posedge clk);
      pin_n <= 1'b0;
      ps <= s;
      repeat (6) @(posedge clk);
      pin_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   //----
   // sequence
   //----
   initial begin
      do_reset();
      rchk(`RCPC_A_RCC, 8'h1F, 8'h1C);
      rchk(`RCPC_A_STK, 8'hFF, 8'h0A);
      wr(`RCPC_A_CFG, 32'h5);
      do_reset();
      rchk(`RCPC_A_RCC, 8'h5F, 8'h5C);
      cmp("sw brownout enable", 32'h1, sbe);
      pulse(6, 0);
      pulse(1, 0);
      cmp("pc", 32'h0, pc);
      rchk(`RCPC_A_RCC, 8'h5F, 8'h4C);
      wr(`RCPC_A_CFG, 32'h4);
      pulse(0, 0);
      rchk(`RCPC_A_RCC, 8'h5F, 8'h1C);
      pulse(6, 1);
      pulse(2, 1);
      cmp("reset", 32'h1, cr);
      rchk(`RCPC_A_RCC, 8'h5F, 8'h14);
      pulse(6, 2);
      pin_hit(2);
      cmp("pc", 32'h0, pc);
      rchk(`RCPC_A_RCC, 8'h5F, 8'h18);
      pulse(6, 0);
      pin_hit(0);
      cmp("pc", 32'h0, pc);
      rchk(`RCPC_A_RCC, 8'h5F, 8'h18);
      pulse(6, 3);
      pulse(2, 3);
      cmp("pc", 32'h4, pc);
      rchk(`RCPC_A_RCC, 8'h5F, 8'h10);
      // brown-out in idle raises the power-down flag again so the wakes must clear it
      pulse(0, 2);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         gh <= (i == 1);
         gl <= (i == 2);
         ih <= (i == 1);
         pulse(3, 2);
         cmp("wake pc", (i == 0) ? 21'h2 : (i == 1) ? `RCPC_V_HI : `RCPC_V_LO, pc);
      end
      rchk(`RCPC_A_RCC, 8'h5F, 8'h18);
      for (int i = 0; i < 3; i++) begin
         wr(`RCPC_A_CFG, (i == 2) ? 32'h0 : 32'h4);
         wr(`RCPC_A_STK, 32'h0);
         pulse(6, 0);
         pulse((i == 0) ? 4 : 5, 0);
         cmp("stack pc", 32'h0, pc);
         cmp("stack reset", {31'h0, i != 2}, cr);
         rchk(`RCPC_A_STK, 8'hFF, (i == 0) ? 8'h8A : 8'h4A);
      end
      // clock enable low: an advance strobe must leave the counter alone
      @(posedge clk) en <= 1'b0;
      pulse(6, 0);
      cmp("frozen pc", 32'h0, pc);
      @(posedge clk) en <= 1'b1;
      wr(`RCPC_A_HLAT, 32'h12);
      wr(`RCPC_A_ULAT, 32'h01);
      wr(`RCPC_A_PLO, 32'h35);
      cmp("pc", 32'h011234, pc);
      repeat (2) @(posedge clk);
      #1;
      cmp("fetch", 32'h0, fd);
      @(posedge clk) jaddr <= 21'h0ABCDF;
      pulse(7, 0);
      cmp("pc", 32'h0ABCDE, pc);
      rchk(`RCPC_A_PLO, 8'hFF, 8'hDE);
      rchk(`RCPC_A_HLAT, 8'hFF, 8'hBC);
      rchk(`RCPC_A_ULAT, 8'hFF, 8'h0A);
      pulse(0, 0);
      rchk(`RCPC_A_HLAT, 8'hFF, 8'hBC);
      @(posedge clk) jaddr <= 21'h000100;
      pulse(7, 0);
      repeat (2) @(posedge clk);
      #1;
      cmp("fetch", 32'h5A, fd);
      rd(5'h1C);
      cmp("rresp", `RCPC_RESP_ERR, rr);
      wr(5'h1C, 32'h1);
      cmp("bresp", `RCPC_RESP_ERR, rr);
      finish_test();
   end
   // watchdog against a hung handshake
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
endmodule
